// [pkg/rats_pkg.sv]
// register access type package: offsets, field layout, reset values,
// access kinds and the request/answer carriers of the register bank.
// assumes a 32-bit data path and byte strobes from the requester.
package rats_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned OFFS_W = 12;
    localparam int unsigned N_REGS = 8;

    // access kinds that a field may take
    typedef enum logic [2:0] {
        RATS_RW,
        RATS_RO,
        RATS_RC,
        RATS_RWC,
        RATS_RW1C,
        RATS_RW1S,
        RATS_W1C,
        RATS_WO
    } rats_kind_t;

    // byte offsets from the module base
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_EVRC = 12'h008;
    localparam logic [11:0] OFF_ERRS = 12'h00c;
    localparam logic [11:0] OFF_RIS = 12'h010;
    localparam logic [11:0] OFF_ENAS = 12'h014;
    localparam logic [11:0] OFF_ICLR = 12'h018;
    localparam logic [11:0] OFF_CMD = 12'h01c;

    // register indices, one-hot select positions
    localparam int unsigned IX_CTRL = 0;
    localparam int unsigned IX_STAT = 1;
    localparam int unsigned IX_EVRC = 2;
    localparam int unsigned IX_ERRS = 3;
    localparam int unsigned IX_RIS = 4;
    localparam int unsigned IX_ENAS = 5;
    localparam int unsigned IX_ICLR = 6;
    localparam int unsigned IX_CMD = 7;

    // field positions, upper down to lower, inclusive
    localparam int unsigned CFG_HI = 31;
    localparam int unsigned CFG_LO = 15;
    localparam int unsigned MODE_HI = 7;
    localparam int unsigned MODE_LO = 0;
    localparam int unsigned CFG_W = CFG_HI - CFG_LO + 1;
    localparam int unsigned MODE_W = MODE_HI - MODE_LO + 1;
    localparam int unsigned STAT_W = 16;
    localparam int unsigned EV_W = 8;

    // values after reset
    localparam logic [16:0] RST_CFG = 17'h00000;
    localparam logic [15:0] RST_STAT = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'h01;
    localparam logic [7:0] RST_EV = 8'h00;
    localparam logic [7:0] RST_ENAS = 8'h00;
    localparam logic [31:0] RST_CMD = 32'h00000000;
    localparam logic [31:0] RD_UNDEF = 32'h00000000;

    // answer follows the taking edge by this many cycles
    localparam int unsigned RSP_LAT = 1;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } rats_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] rdata;
    } rats_rsp_t;

    typedef struct packed {
        logic [15:0] status;
        logic [7:0] evrc_set;
        logic [7:0] errs_set;
        logic [7:0] ris_set;
        logic [7:0] enas_clr;
    } rats_hw_t;

    // expand byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // offset to one-hot register select; all zero when unmapped
    function automatic logic [7:0] offs_sel(input logic [11:0] offs);
        logic [7:0] s;
        s = 8'h00;
        unique case (offs)
            OFF_CTRL: s[IX_CTRL] = 1'b1;
            OFF_STAT: s[IX_STAT] = 1'b1;
            OFF_EVRC: s[IX_EVRC] = 1'b1;
            OFF_ERRS: s[IX_ERRS] = 1'b1;
            OFF_RIS: s[IX_RIS] = 1'b1;
            OFF_ENAS: s[IX_ENAS] = 1'b1;
            OFF_ICLR: s[IX_ICLR] = 1'b1;
            OFF_CMD: s[IX_CMD] = 1'b1;
            default: s = 8'h00;
        endcase
        return s;
    endfunction

endpackage

// [design/rats_decode.sv]
// address decoder of the register bank: base compare plus offset select.
// assumes the base is aligned to the 4 KiB window of the offset field.
`timescale 1ns/1ps
module rats_decode #(
    parameter logic [31:0] BASE = 32'h40000000
) (
    input wire logic [31:0] addr,
    output logic hit,
    output logic [7:0] sel
);
    logic base_ok;

    // upper bits name the module, lower bits the register
    always_comb begin
        base_ok = (addr[31:12] == BASE[31:12]);
        sel = base_ok ? rats_pkg::offs_sel(addr[11:0]) : 8'h00;
        hit = |sel;
    end
endmodule

// [design/rats_field.sv]
// one register field of a chosen access kind, with hardware set/clear.
// assumes wr and rd are single-cycle and never both high for one field.
`timescale 1ns/1ps
module rats_field #(
    parameter int unsigned W = 8,
    parameter rats_pkg::rats_kind_t KIND = rats_pkg::RATS_RW,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr,
    input wire logic rd,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] wmask,
    input wire logic [W-1:0] hw_set,
    input wire logic [W-1:0] hw_clr,
    output logic [W-1:0] q
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;
    logic [W-1:0] wbits;

    // next value per kind; in the RC, RWC, RW1C and W1C kinds hardware set is or-ed last so it wins
    always_comb begin
        wbits = wdata & wmask;
        q_nxt = q_r;
        unique case (KIND)
            rats_pkg::RATS_RW: if (wr) q_nxt = (q_r & ~wmask) | wbits;
            rats_pkg::RATS_RO: q_nxt = hw_set;
            rats_pkg::RATS_RC: q_nxt = (rd ? '0 : q_r) | hw_set;
            rats_pkg::RATS_RWC: q_nxt = (wr ? '0 : q_r) | hw_set;
            rats_pkg::RATS_RW1C,
            rats_pkg::RATS_W1C: q_nxt = (wr ? (q_r & ~wbits) : q_r) | hw_set;
            rats_pkg::RATS_RW1S: q_nxt = (q_r & ~hw_clr) | (wr ? wbits : '0);
            rats_pkg::RATS_WO: if (wr) q_nxt = wbits;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// [design/rats_bank.sv]
// register bank showing each field access kind behind a simple
// request port; one request per cycle, answer one cycle later.
// assumes the requester holds no request open and keeps its own ordering.
// assumes the hardware event inputs are levels in the same clock domain.
//
// Contract
// - clear-on-read field returns value, then clears
// - read-write field stores and returns written value
// - any write clears a write-clear field
// - write-one-clear: zeros keep, ones clear bit
// - write back read status clears only those
// - write-one-set: zeros ignored, readable back
// - write-only one-clear register, undefined read
// - reserved bits read zero, not relied upon
// - register at module base plus fixed offset
// - multi-bit fields occupy contiguous inclusive ranges
// - write-only register accepts writes, reads harmless
// - every field takes its reset value
`timescale 1ns/1ps
module rats_bank #(
    parameter logic [31:0] BASE = 32'h40000000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire rats_pkg::rats_req_t req,
    output rats_pkg::rats_rsp_t rsp,
    input wire rats_pkg::rats_hw_t hw,
    output logic [16:0] ctrl_cfg,
    output logic [7:0] ctrl_mode,
    output logic [7:0] ris,
    output logic [7:0] enas,
    output logic [7:0] errs,
    output logic cmd_valid,
    output logic [31:0] cmd_data
);
    // request decode and lane mask
    logic hit;
    logic [7:0] sel;
    logic wr_any;
    logic rd_any;
    logic [7:0] wr_sel;
    logic [7:0] rd_sel;
    logic [31:0] wmask;
    logic [31:0] wdata;

    // field contents that only the read mux sees, and the shared ris write path
    logic [15:0] stat_q;
    logic [7:0] evrc_q;
    logic [7:0] ris_wdata;
    logic [7:0] ris_wmask;
    logic ris_wr;

    // answer and command state
    logic [31:0] rdata;
    rats_pkg::rats_rsp_t rsp_r;
    rats_pkg::rats_rsp_t rsp_nxt;
    logic cmd_valid_r;
    logic cmd_valid_nxt;
    logic [31:0] cmd_data_r;
    logic [31:0] cmd_data_nxt;

    // module base compare plus per-register offset select
    rats_decode #(
        .BASE(BASE)
    ) u_decode (
        .addr(req.addr),
        .hit(hit),
        .sel(sel)
    );

    // a request is taken on the edge that sees valid; no wait states,
    // so every side effect lands on that same edge
    always_comb begin
        wr_any = req.valid && req.write;
        rd_any = req.valid && !req.write;
        wr_sel = wr_any ? sel : 8'h00;
        rd_sel = rd_any ? sel : 8'h00;
        // lane mask built once and shared by every written field; evrc takes none
        wmask = rats_pkg::strb_mask(req.strb);
        wdata = req.wdata;
    end

    // control word: two read-write fields, bits between them reserved
    rats_field #(
        .W(rats_pkg::CFG_W),
        .KIND(rats_pkg::RATS_RW),
        .RST(rats_pkg::RST_CFG)
    ) u_cfg (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr_sel[rats_pkg::IX_CTRL]),
        .rd(1'b0),
        .wdata(wdata[rats_pkg::CFG_HI:rats_pkg::CFG_LO]),
        .wmask(wmask[rats_pkg::CFG_HI:rats_pkg::CFG_LO]),
        .hw_set(17'h00000),
        .hw_clr(17'h00000),
        .q(ctrl_cfg)
    );

    // mode byte on the lowest lane; resets to a non-zero value
    rats_field #(
        .W(rats_pkg::MODE_W),
        .KIND(rats_pkg::RATS_RW),
        .RST(rats_pkg::RST_MODE)
    ) u_mode (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr_sel[rats_pkg::IX_CTRL]),
        .rd(1'b0),
        .wdata(wdata[rats_pkg::MODE_HI:rats_pkg::MODE_LO]),
        .wmask(wmask[rats_pkg::MODE_HI:rats_pkg::MODE_LO]),
        .hw_set(8'h00),
        .hw_clr(8'h00),
        .q(ctrl_mode)
    );

    // status mirror: written data is dropped, so whatever software
    // writes back here has no effect
    rats_field #(
        .W(rats_pkg::STAT_W),
        .KIND(rats_pkg::RATS_RO),
        .RST(rats_pkg::RST_STAT)
    ) u_stat (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr_sel[rats_pkg::IX_STAT]),
        .rd(1'b0),
        .wdata(wdata[15:0]),
        .wmask(wmask[15:0]),
        .hw_set(hw.status),
        .hw_clr(16'h0000),
        .q(stat_q)
    );

    // sticky event bits emptied by the read that reports them; the
    // flop holds the pre-clear value for the answer register
    rats_field #(
        .W(rats_pkg::EV_W),
        .KIND(rats_pkg::RATS_RC),
        .RST(rats_pkg::RST_EV)
    ) u_evrc (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(1'b0),
        .rd(rd_sel[rats_pkg::IX_EVRC]),
        .wdata(8'h00),
        .wmask(8'h00),
        .hw_set(hw.evrc_set),
        .hw_clr(8'h00),
        .q(evrc_q)
    );

    // error bits: any write, whatever the data or strobes, empties them
    rats_field #(
        .W(rats_pkg::EV_W),
        .KIND(rats_pkg::RATS_RWC),
        .RST(rats_pkg::RST_EV)
    ) u_errs (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr_sel[rats_pkg::IX_ERRS]),
        .rd(1'b0),
        .wdata(wdata[7:0]),
        .wmask(wmask[7:0]),
        .hw_set(hw.errs_set),
        .hw_clr(8'h00),
        .q(errs)
    );

    // interrupt status is cleared through its own readable offset or
    // through the write-only clear offset; both share one storage so
    // an event can never be lost between the two views
    always_comb begin
        ris_wr = wr_sel[rats_pkg::IX_RIS] || wr_sel[rats_pkg::IX_ICLR];
        ris_wdata = wdata[7:0];
        ris_wmask = wmask[7:0];
    end

    rats_field #(
        .W(rats_pkg::EV_W),
        .KIND(rats_pkg::RATS_RW1C),
        .RST(rats_pkg::RST_EV)
    ) u_ris (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(ris_wr),
        .rd(1'b0),
        .wdata(ris_wdata),
        .wmask(ris_wmask),
        .hw_set(hw.ris_set),
        .hw_clr(8'h00),
        .q(ris)
    );

    // enable bits: software sets with ones, hardware retires them;
    // a software set in the same cycle as a retire keeps the bit
    rats_field #(
        .W(rats_pkg::EV_W),
        .KIND(rats_pkg::RATS_RW1S),
        .RST(rats_pkg::RST_ENAS)
    ) u_enas (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr_sel[rats_pkg::IX_ENAS]),
        .rd(1'b0),
        .wdata(wdata[7:0]),
        .wmask(wmask[7:0]),
        .hw_set(8'h00),
        .hw_clr(hw.enas_clr),
        .q(enas)
    );

    // write-only command word: a write leaves a one-cycle strobe with
    // the strobed lanes; reads neither pulse nor change anything
    always_comb begin
        cmd_valid_nxt = wr_sel[rats_pkg::IX_CMD];
        cmd_data_nxt = cmd_data_r;
        if (wr_sel[rats_pkg::IX_CMD]) begin
            cmd_data_nxt = wdata & wmask;
        end
    end

    // strobe lasts one cycle; the data word holds for the consumer
    // until the next command write, so it may be sampled late
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_valid_r <= 1'b0;
            cmd_data_r <= rats_pkg::RST_CMD;
        end else begin
            cmd_valid_r <= cmd_valid_nxt;
            cmd_data_r <= cmd_data_nxt;
        end
    end

    // read mux; unused and reserved bits are zero-filled here, but the
    // value is a courtesy only, software must not count on it
    always_comb begin
        rdata = 32'h00000000;
        // select is one-hot or all zero, so at most one item applies
        unique case (1'b1)
            sel[rats_pkg::IX_CTRL]: begin
                rdata[rats_pkg::CFG_HI:rats_pkg::CFG_LO] = ctrl_cfg;
                rdata[rats_pkg::MODE_HI:rats_pkg::MODE_LO] = ctrl_mode;
            end
            sel[rats_pkg::IX_STAT]: begin
                rdata[15:0] = stat_q;
            end
            sel[rats_pkg::IX_EVRC]: begin
                rdata[7:0] = evrc_q;
            end
            sel[rats_pkg::IX_ERRS]: begin
                rdata[7:0] = errs;
            end
            sel[rats_pkg::IX_RIS]: begin
                rdata[7:0] = ris;
            end
            sel[rats_pkg::IX_ENAS]: begin
                rdata[7:0] = enas;
            end
            sel[rats_pkg::IX_ICLR]: begin
                rdata = rats_pkg::RD_UNDEF;
            end
            sel[rats_pkg::IX_CMD]: begin
                rdata = rats_pkg::RD_UNDEF;
            end
            default: rdata = 32'h00000000;
        endcase
    end

    // answer register: exactly one cycle after the taking edge, error
    // flagged for an address outside the map; write data is dropped then
    always_comb begin
        rsp_nxt = '0;
        if (req.valid) begin
            rsp_nxt.valid = 1'b1;
            if (!hit) begin
                // refused: nothing touched, no data returned
                rsp_nxt.err = 1'b1;
            end else if (rd_any) begin
                rsp_nxt.rdata = rdata;
            end
        end
    end

    // answer lives for exactly one cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // every output comes straight from a flop
    assign rsp = rsp_r;
    assign cmd_valid = cmd_valid_r;
    assign cmd_data = cmd_data_r;
endmodule

// [verif/rats_bank_props.sv]
// assertions on the register bank ports: latency, decode, field kinds.
// assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module rats_bank_props #(
    parameter logic [31:0] BASE = 32'h40000000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire rats_pkg::rats_req_t req,
    input wire rats_pkg::rats_rsp_t rsp,
    input wire rats_pkg::rats_hw_t hw,
    input wire logic [16:0] ctrl_cfg,
    input wire logic [7:0] ctrl_mode,
    input wire logic [7:0] ris,
    input wire logic [7:0] enas,
    input wire logic [7:0] errs,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_data
);
    logic [31:0] wm;
    logic [7:0] wb;
    // lane mask and the written low byte under it
    assign wm = {{8{req.strb[3]}}, {8{req.strb[2]}}, {8{req.strb[1]}}, {8{req.strb[0]}}};
    assign wb = req.wdata[7:0] & wm[7:0];

    function automatic logic at(input logic [31:0] a, input logic [11:0] o);
        return a == (BASE + {20'h00000, o});
    endfunction

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_wr(logic [11:0] o);
        req.valid && req.write && at(req.addr, o);
    endsequence
    sequence s_rd(logic [11:0] o);
        req.valid && !req.write && at(req.addr, o);
    endsequence

    property p_lat;
        req.valid |=> rsp.valid;
    endproperty
    a_lat: assert property (p_lat) else $error("answer late");
    property p_idle;
        !req.valid |=> !rsp.valid;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_dec;
        req.valid && req.addr[31:12] != BASE[31:12] |=> rsp.err && rsp.rdata == 32'h00000000;
    endproperty
    a_dec: assert property (p_dec) else $error("foreign base not refused");
    property p_ctrl;
        s_wr(rats_pkg::OFF_CTRL) ##0 req.strb == 4'hf
            |=> ctrl_cfg == $past(req.wdata[31:15]) && ctrl_mode == $past(req.wdata[7:0]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl not stored");
    property p_rsv;
        s_rd(rats_pkg::OFF_CTRL) |=> rsp.rdata[14:8] == 7'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_rc;
        s_rd(rats_pkg::OFF_EVRC) ##0 hw.evrc_set == 8'h00 ##1 s_rd(rats_pkg::OFF_EVRC)
            |=> rsp.rdata[7:0] == 8'h00;
    endproperty
    a_rc: assert property (p_rc) else $error("read did not clear");
    property p_wc;
        s_wr(rats_pkg::OFF_ERRS) ##0 hw.errs_set == 8'h00 |=> errs == 8'h00;
    endproperty
    a_wc: assert property (p_wc) else $error("write did not clear");
    property p_w1c;
        (s_wr(rats_pkg::OFF_RIS) or s_wr(rats_pkg::OFF_ICLR)) ##0 hw.ris_set == 8'h00
            |=> ris == ($past(ris) & ~$past(wb));
    endproperty
    a_w1c: assert property (p_w1c) else $error("one-clear wrong");
    property p_w1s;
        s_wr(rats_pkg::OFF_ENAS) ##0 hw.enas_clr == 8'h00 |=> enas == ($past(enas) | $past(wb));
    endproperty
    a_w1s: assert property (p_w1s) else $error("one-set wrong");
    property p_hw;
        hw.ris_set != 8'h00 |=> (ris & $past(hw.ris_set)) == $past(hw.ris_set);
    endproperty
    a_hw: assert property (p_hw) else $error("event lost");
    property p_cmd;
        s_wr(rats_pkg::OFF_CMD) |=> cmd_valid && cmd_data == $past(req.wdata & wm);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command write lost");
    property p_rdfx;
        s_rd(rats_pkg::OFF_ICLR) ##0 hw.ris_set == 8'h00 |=> ris == $past(ris);
    endproperty
    a_rdfx: assert property (p_rdfx) else $error("read had effect");
endmodule

bind rats_bank rats_bank_props #(.BASE(BASE)) u_rats_bank_props (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp), .hw(hw),
    .ctrl_cfg(ctrl_cfg), .ctrl_mode(ctrl_mode), .ris(ris), .enas(enas),
    .errs(errs), .cmd_valid(cmd_valid), .cmd_data(cmd_data));

// [verif/rats_cpu_model.sv]
// processor model: one-word requests on the bank port, answer collected.
// assumes the bank takes every request; bench holds it off during reset.
`timescale 1ns/1ps
module rats_cpu_model (
    input wire logic clk_sys,
    output rats_pkg::rats_req_t req,
    input wire rats_pkg::rats_rsp_t rsp
);
    initial begin
        req = '0;
    end

    // n copies back to back; answer of the last one returned
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input int n, output logic [31:0] rd,
                        output logic e, output logic ok);
        ok = 1'b0;
        rd = 32'h00000000;
        e = 1'b0;
        @(posedge clk_sys);
        #1;
        req = '{valid: 1'b1, write: w, addr: a, wdata: d, strb: s};
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            #1;
        end
        // released lines flip, so a stale copy never looks valid
        req = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d, strb: ~s};
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rsp.valid === 1'b1) begin
                ok = 1'b1;
                rd = rsp.rdata;
                e = rsp.err;
            end else begin
                @(posedge clk_sys);
                #1;
            end
        end
    endtask
endmodule

// [verif/rats_bank_tb.sv]
// self-checking bench of the register bank, processor model on the port.
// assumes the hardware event inputs are driven only here.
`timescale 1ns/1ps
module rats_bank_tb;
    localparam logic [31:0] BASE = 32'h40000000;
    logic clk_sys;
    logic rst;
    rats_pkg::rats_req_t req;
    rats_pkg::rats_rsp_t rsp;
    rats_pkg::rats_hw_t hw;
    logic [16:0] ctrl_cfg;
    logic [7:0] ctrl_mode;
    logic [7:0] ris;
    logic [7:0] enas;
    logic [7:0] errs;
    logic cmd_valid;
    logic [31:0] cmd_data;
    logic [31:0] rd;
    logic e;
    int bad_count = 0;
    int check_count = 0;

    rats_bank #(.BASE(BASE)) u_rats_bank (.clk_sys(clk_sys), .rst(rst), .req(req),
        .rsp(rsp), .hw(hw), .ctrl_cfg(ctrl_cfg), .ctrl_mode(ctrl_mode), .ris(ris),
        .enas(enas), .errs(errs), .cmd_valid(cmd_valid), .cmd_data(cmd_data));
    rats_cpu_model u_rats_cpu_model (.clk_sys(clk_sys), .req(req), .rsp(rsp));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one access at base plus o; a lost answer ends the run
    task automatic acc(input logic w, input logic [31:0] o, input logic [31:0] d,
                       input logic [3:0] s, input int n);
        logic ok;
        u_rats_cpu_model.xfer(w, BASE + o, d, s, n, rd, e, ok);
        if (!ok) begin
            bad_count++;
            close_out();
        end
    endtask

    // one-cycle event pulse: evrc set, errs set, ris set, enas clear
    task automatic hw_ev(input logic [7:0] rc, input logic [7:0] er, input logic [7:0] ri,
                         input logic [7:0] ec);
        @(posedge clk_sys);
        #1;
        {hw.evrc_set, hw.errs_set, hw.ris_set, hw.enas_clr} = {rc, er, ri, ec};
        @(posedge clk_sys);
        #1;
        {hw.evrc_set, hw.errs_set, hw.ris_set, hw.enas_clr} = 32'h00000000;
    endtask

    task automatic t_rw;
        chk({ctrl_cfg, 7'h00, ctrl_mode}, 32'h00000001);
        chk({8'h00, ris, enas, errs}, 32'h00000000);
        acc(1'b1, 32'h0, 32'hffffffff, 4'hf, 1);
        chk({ctrl_cfg, 7'h00, ctrl_mode}, 32'hffff80ff);
        acc(1'b0, 32'h0, 32'h0, 4'hf, 1);
        chk(rd, 32'hffff80ff);
        acc(1'b1, 32'h0, {rd[31:8], 8'h5a}, 4'hf, 1);
        acc(1'b1, 32'h0, 32'h0, 4'h2, 1);
        chk({ctrl_cfg, 7'h00, ctrl_mode}, 32'hffff005a);
        acc(1'b1, 32'h4, 32'h0, 4'hf, 1);
        acc(1'b0, 32'h4, 32'h0, 4'hf, 1);
        chk(rd, 32'h0000a5c3);
        $display("test rw done");
    endtask

    task automatic t_rc;
        hw_ev(8'h81, 8'h3c, 8'h00, 8'h00);
        acc(1'b0, 32'h8, 32'h0, 4'hf, 1);
        chk(rd, 32'h00000081);
        acc(1'b0, 32'h8, 32'h0, 4'hf, 2);
        chk(rd, 32'h00000000);
        // event on the very edge that takes the read
        fork
            acc(1'b0, 32'h8, 32'h0, 4'hf, 1);
            hw_ev(8'h10, 8'h00, 8'h00, 8'h00);
        join
        acc(1'b0, 32'h8, 32'h0, 4'hf, 1);
        chk(rd, 32'h00000010);
        acc(1'b0, 32'hc, 32'h0, 4'hf, 1);
        chk(rd, 32'h0000003c);
        acc(1'b1, 32'hc, 32'h0, 4'h0, 1);
        chk({24'h000000, errs}, 32'h00000000);
        $display("test rc done");
    endtask

    task automatic t_w1;
        hw_ev(8'h00, 8'h00, 8'hf0, 8'h00);
        acc(1'b0, 32'h10, 32'h0, 4'hf, 1);
        hw_ev(8'h00, 8'h00, 8'h0f, 8'h00);
        acc(1'b1, 32'h10, rd, 4'hf, 1);
        chk({24'h000000, ris}, 32'h0000000f);
        acc(1'b1, 32'h18, 32'h00000003, 4'hf, 1);
        chk({24'h000000, ris}, 32'h0000000c);
        acc(1'b0, 32'h18, 32'h0, 4'hf, 1);
        chk({rd[31:8], ris}, 32'h0000000c);
        fork
            acc(1'b1, 32'h18, 32'hff, 4'hf, 1);
            hw_ev(8'h00, 8'h00, 8'h01, 8'h00);
        join
        chk({24'h000000, ris}, 32'h00000001);
        acc(1'b1, 32'h14, 32'h05, 4'hf, 1);
        acc(1'b1, 32'h14, 32'h0a, 4'hf, 1);
        acc(1'b1, 32'h14, 32'h00, 4'hf, 1);
        acc(1'b0, 32'h14, 32'h0, 4'hf, 1);
        chk(rd, 32'h0000000f);
        hw_ev(8'h00, 8'h00, 8'h00, 8'h01);
        chk({24'h000000, enas}, 32'h0000000e);
        $display("test w1 done");
    endtask

    task automatic t_cmd;
        acc(1'b1, 32'h1c, 32'h1234abcd, 4'h5, 1);
        chk({cmd_valid, cmd_data[30:0]}, 32'h803400cd);
        acc(1'b0, 32'h1c, 32'h0, 4'hf, 1);
        chk({cmd_valid, cmd_data[30:0]}, 32'h003400cd);
        acc(1'b0, 32'h20, 32'h0, 4'hf, 1);
        chk({e, rd[30:0]}, 32'h80000000);
        acc(1'b1, 32'h1000, 32'h0, 4'hf, 1);
        chk({31'h0, e}, 32'h00000001);
        $display("test cmd done");
    endtask

    initial begin
        rst = 1'b1;
        hw = '0;
        hw.status = 16'ha5c3;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_rw();
        t_rc();
        t_w1();
        t_cmd();
        close_out();
    end
endmodule
